// *** hdl/jir_bsr.v ***
`timescale 1ns/100ps
module jir_bsr #(
  parameter LEN = 297
) (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire capture,
  input wire shift,
  input wire update,
  input wire tdi,
  input wire [LEN-1:0] cap_vec,
  output wire so,
  output wire [LEN-1:0] upd_q
);
  reg [LEN-1:0] sh_q;
  reg [LEN-1:0] lat_q;
  genvar i;
  generate
    for (i = 0; i < LEN; i = i + 1) begin : g_cell
      wire nxt;
      if (i == LEN - 1) begin : g_top
        assign nxt = tdi;
      end else begin : g_mid
        assign nxt = sh_q[i+1];
      end
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          sh_q[i] <= 1'b0;
          lat_q[i] <= 1'b0;
        end else if (ce) begin
          if (capture) begin
            sh_q[i] <= cap_vec[i];
          end else if (shift) begin
            sh_q[i] <= nxt;
          end
          if (update) begin
            lat_q[i] <= sh_q[i];
          end
        end
      end
    end
  endgenerate
  assign so = sh_q[0];
  assign upd_q = lat_q;
endmodule

// *** hdl/jir_regs.vh ***
// Behaviour
// - 32-bit identity chain selected by IDCODE
// - bits 31..28 hold silicon version
// - bits 27..12 hold part number
// - bits 11..1 hold manufacturer field
// - identity bit 0 always one
// - bypass is one stage tdi to tdo
// - bypass for BYPASS, HIGHZ, unsupported codes
// - 00000 is EXTEST on boundary chain
// - 00001 is SAMPLE/PRELOAD on boundary chain
// - 00010 is IDCODE, identity shifts out
// - 00011 is HIGHZ, pins float, bypass
// - codes 00100..11110 act as BYPASS
// - 11111 is BYPASS through one stage
// - after EXTEST stay in test until device reset, trst does not clear it
// - tdi pull-up makes open scan BYPASS
// - EXTEST captures pins, update drives pins
// - SAMPLE captures every pin state
// - SAMPLE update loads latches, no drive before any EXTEST
// - bypass shortens 297-bit chain to one
// - controller reset loads IDCODE
// - before any EXTEST, codes other than EXTEST and HIGHZ leave function untouched
// - instruction capture loads 00001
// - shift in msb rising, out lsb falling
// - enable zero floats, one drives pin
`ifndef JIR_REGS_VH
`define JIR_REGS_VH
`define JIR_IR_W 5
`define JIR_IR_EXTEST 5'h00
`define JIR_IR_SAMPLE 5'h01
`define JIR_IR_IDCODE 5'h02
`define JIR_IR_HIGHZ 5'h03
`define JIR_IR_BYPASS 5'h1f
`define JIR_IR_CAPTURE 5'h01
`define JIR_ID_W 32
`define JIR_ID_VER_MSB 31
`define JIR_ID_VER_LSB 28
`define JIR_ID_PART_MSB 27
`define JIR_ID_PART_LSB 12
`define JIR_ID_MAKER_MSB 11
`define JIR_ID_MAKER_LSB 1
`define JIR_ID_ONE_BIT 0
`define JIR_BSR_LEN 297
`define JIR_BYP_CAPTURE 1'h0
`endif

// *** hdl/jir_sync.v ***
`timescale 1ns/100ps
module jir_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire [WIDTH-1:0] d,
  output wire [WIDTH-1:0] q
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg meta_q;
      reg sync_q;
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_q <= RST_VAL[i];
          sync_q <= RST_VAL[i];
        end else if (ce) begin
          meta_q <= d[i];
          sync_q <= meta_q;
        end
      end
      assign q[i] = sync_q;
    end
  endgenerate
endmodule

// *** hdl/jir_top.v ***
`timescale 1ns/100ps
`include "jir_regs.vh"
module jir_top #(
  parameter BSR_LEN = `JIR_BSR_LEN,
  // arbitrary identity values, not those of any real part
  parameter [3:0] ID_VERSION = 4'h1,
  parameter [15:0] ID_PART = 16'h1234,
  parameter [10:0] ID_MAKER = 11'h055,
  // set bit i when chain bit i is the enable of the value bit i-1
  parameter [BSR_LEN-1:0] EN_MASK = {BSR_LEN{1'b0}}
) (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire tck,
  input wire tms,
  input wire tdi,
  input wire trst_n,
  output wire tdo,
  output wire tdo_oe,
  input wire [BSR_LEN-1:0] pad_lvl,
  input wire [BSR_LEN-1:0] core_en,
  output wire bscan_ovr,
  output wire [BSR_LEN-1:0] bscan_val,
  output wire [BSR_LEN-1:0] bscan_en,
  output wire [`JIR_IR_W-1:0] cur_instr,
  output wire test_mode
);
  localparam [3:0] S_TLR = 4'h0;
  localparam [3:0] S_RTI = 4'h1;
  localparam [3:0] S_SEL_DR = 4'h2;
  localparam [3:0] S_CAP_DR = 4'h3;
  localparam [3:0] S_SH_DR = 4'h4;
  localparam [3:0] S_EX1_DR = 4'h5;
  localparam [3:0] S_PA_DR = 4'h6;
  localparam [3:0] S_EX2_DR = 4'h7;
  localparam [3:0] S_UP_DR = 4'h8;
  localparam [3:0] S_SEL_IR = 4'h9;
  localparam [3:0] S_CAP_IR = 4'ha;
  localparam [3:0] S_SH_IR = 4'hb;
  localparam [3:0] S_EX1_IR = 4'hc;
  localparam [3:0] S_PA_IR = 4'hd;
  localparam [3:0] S_EX2_IR = 4'he;
  localparam [3:0] S_UP_IR = 4'hf;

  localparam [1:0] SEL_BYP = 2'h0;
  localparam [1:0] SEL_BSR = 2'h1;
  localparam [1:0] SEL_ID = 2'h2;

  // all four test pins are asynchronous to clk
  wire [3:0] pin_s;
  wire tck_s;
  wire tms_s;
  wire tdi_s;
  wire trst_s_n;

  jir_sync #(
    .WIDTH(4),
    .RST_VAL(4'he) // tck idles low: a reset value of one gave a false edge
  ) u_pin_sync (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .d({trst_n, tdi, tms, tck}),
    .q(pin_s)
  );

  assign tck_s = pin_s[0];
  assign tms_s = pin_s[1];
  // pad pull-up: an open tdi reads one, shifts 11111
  assign tdi_s = pin_s[2];
  assign trst_s_n = pin_s[3];

  wire [BSR_LEN-1:0] pad_s;

  jir_sync #(
    .WIDTH(BSR_LEN),
    .RST_VAL({BSR_LEN{1'b0}})
  ) u_pad_sync (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .d(pad_lvl),
    .q(pad_s)
  );

  reg tck_d_q;
  wire tck_rise;
  wire tck_fall;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tck_d_q <= 1'b0;
    end else if (ce) begin
      tck_d_q <= tck_s;
    end
  end

  assign tck_rise = tck_s & ~tck_d_q;
  assign tck_fall = ~tck_s & tck_d_q;

  reg [3:0] st_q;
  reg [3:0] st_d;

  always @* begin
    case (st_q)
      S_TLR: st_d = tms_s ? S_TLR : S_RTI;
      S_RTI: st_d = tms_s ? S_SEL_DR : S_RTI;
      S_SEL_DR: st_d = tms_s ? S_SEL_IR : S_CAP_DR;
      S_CAP_DR: st_d = tms_s ? S_EX1_DR : S_SH_DR;
      S_SH_DR: st_d = tms_s ? S_EX1_DR : S_SH_DR;
      S_EX1_DR: st_d = tms_s ? S_UP_DR : S_PA_DR;
      S_PA_DR: st_d = tms_s ? S_EX2_DR : S_PA_DR;
      S_EX2_DR: st_d = tms_s ? S_UP_DR : S_SH_DR;
      S_UP_DR: st_d = tms_s ? S_SEL_DR : S_RTI;
      S_SEL_IR: st_d = tms_s ? S_TLR : S_CAP_IR;
      S_CAP_IR: st_d = tms_s ? S_EX1_IR : S_SH_IR;
      S_SH_IR: st_d = tms_s ? S_EX1_IR : S_SH_IR;
      S_EX1_IR: st_d = tms_s ? S_UP_IR : S_PA_IR;
      S_PA_IR: st_d = tms_s ? S_EX2_IR : S_PA_IR;
      S_EX2_IR: st_d = tms_s ? S_UP_IR : S_SH_IR;
      S_UP_IR: st_d = tms_s ? S_SEL_DR : S_RTI;
      default: st_d = S_TLR;
    endcase
  end

  // trst is a level after the synchroniser; five tms ones also reach reset
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= S_TLR;
    end else if (ce) begin
      if (!trst_s_n) begin
        st_q <= S_TLR;
      end else if (tck_rise) begin
        st_q <= st_d;
      end
    end
  end

  wire in_tlr;
  wire cap_dr;
  wire sh_dr;
  wire upd_dr;
  wire cap_ir;
  wire sh_ir;
  wire upd_ir;

  assign in_tlr = (st_q == S_TLR);
  // capture and shift act on the rising edge that leaves the state
  assign cap_dr = tck_rise & (st_q == S_CAP_DR);
  assign sh_dr = tck_rise & (st_q == S_SH_DR);
  assign cap_ir = tck_rise & (st_q == S_CAP_IR);
  assign sh_ir = tck_rise & (st_q == S_SH_IR);
  // update acts on the falling edge inside the state
  assign upd_dr = tck_fall & (st_q == S_UP_DR);
  assign upd_ir = tck_fall & (st_q == S_UP_IR);

  reg [`JIR_IR_W-1:0] ir_sh_q;
  reg [`JIR_IR_W-1:0] ir_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ir_sh_q <= `JIR_IR_CAPTURE;
      ir_q <= `JIR_IR_IDCODE;
    end else if (ce) begin
      if (cap_ir) begin
        ir_sh_q <= `JIR_IR_CAPTURE;
      end else if (sh_ir) begin
        ir_sh_q <= {tdi_s, ir_sh_q[`JIR_IR_W-1:1]};
      end
      if (in_tlr) begin
        ir_q <= `JIR_IR_IDCODE;
      end else if (upd_ir) begin
        ir_q <= ir_sh_q;
      end
    end
  end

  reg [1:0] sel;
  reg is_extest;
  reg is_sample;
  reg is_highz;

  always @* begin
    sel = SEL_BYP;
    is_extest = 1'b0;
    is_sample = 1'b0;
    is_highz = 1'b0;
    case (ir_q)
      `JIR_IR_EXTEST: begin
        sel = SEL_BSR;
        is_extest = 1'b1;
      end
      `JIR_IR_SAMPLE: begin
        sel = SEL_BSR;
        is_sample = 1'b1;
      end
      `JIR_IR_IDCODE: begin
        sel = SEL_ID;
      end
      `JIR_IR_HIGHZ: begin
        sel = SEL_BYP;
        is_highz = 1'b1;
      end
      `JIR_IR_BYPASS: begin
        sel = SEL_BYP;
      end
      default: begin
        sel = SEL_BYP;
      end
    endcase
  end

  // bypass stage: one bit, captures zero
  reg byp_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      byp_q <= `JIR_BYP_CAPTURE;
    end else if (ce && sel == SEL_BYP) begin
      if (cap_dr) begin
        byp_q <= `JIR_BYP_CAPTURE;
      end else if (sh_dr) begin
        byp_q <= tdi_s;
      end
    end
  end

  wire [`JIR_ID_W-1:0] id_word;
  reg [`JIR_ID_W-1:0] id_sh_q;

  assign id_word[`JIR_ID_VER_MSB:`JIR_ID_VER_LSB] = ID_VERSION;
  assign id_word[`JIR_ID_PART_MSB:`JIR_ID_PART_LSB] = ID_PART;
  assign id_word[`JIR_ID_MAKER_MSB:`JIR_ID_MAKER_LSB] = ID_MAKER;
  assign id_word[`JIR_ID_ONE_BIT] = 1'b1;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      id_sh_q <= {`JIR_ID_W{1'b0}};
    end else if (ce && sel == SEL_ID) begin
      if (cap_dr) begin
        id_sh_q <= id_word;
      end else if (sh_dr) begin
        id_sh_q <= {tdi_s, id_sh_q[`JIR_ID_W-1:1]};
      end
    end
  end

  wire bsr_so;
  wire [BSR_LEN-1:0] bsr_upd;
  wire [BSR_LEN-1:0] bsr_cap;
  wire bsr_sel;

  assign bsr_sel = (sel == SEL_BSR);
  // enable cells: SAMPLE takes the live core enable, EXTEST keeps the latch
  // so the enable cell of a bidirectional pin under EXTEST captures its own update latch
  assign bsr_cap = (EN_MASK & (is_sample ? core_en : bsr_upd))
                 | (~EN_MASK & pad_s);

  jir_bsr #(
    .LEN(BSR_LEN)
  ) u_bsr (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .capture(cap_dr & bsr_sel),
    .shift(sh_dr & bsr_sel),
    .update(upd_dr & bsr_sel),
    .tdi(tdi_s),
    .cap_vec(bsr_cap),
    .so(bsr_so),
    .upd_q(bsr_upd)
  );

  // sticky: only a device reset returns the pins to normal function
  reg test_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      test_q <= 1'b0;
    end else if (ce && is_extest && !in_tlr) begin
      test_q <= 1'b1;
    end
  end

  wire pins_float;
  assign pins_float = is_highz & ~test_q;

  // value bit i is driven when its enable cell i+1 is one
  genvar gi;
  generate
    for (gi = 0; gi < BSR_LEN; gi = gi + 1) begin : g_drv
      if (gi < BSR_LEN - 1) begin : g_has
        // highz floats every pin, even after extest latched enables
        assign bscan_en[gi] = EN_MASK[gi+1] & bsr_upd[gi+1] & test_q & ~is_highz;
      end else begin : g_top
        assign bscan_en[gi] = 1'b0;
      end
    end
  endgenerate

  assign bscan_val = bsr_upd;
  // before any extest, codes other than extest and highz leave the pins to the core
  assign bscan_ovr = test_q | pins_float;
  assign test_mode = test_q;
  assign cur_instr = ir_q;

  reg so_mux;

  always @* begin
    so_mux = byp_q;
    if (st_q == S_SH_IR) begin
      so_mux = ir_sh_q[0];
    end else begin
      case (sel)
        SEL_BSR: so_mux = bsr_so;
        SEL_ID: so_mux = id_sh_q[0];
        default: so_mux = byp_q;
      endcase
    end
  end

  reg tdo_q;
  reg tdo_oe_q;

  // launching on the falling edge gives the tester half a period of setup
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tdo_q <= 1'b1;
      tdo_oe_q <= 1'b0;
    end else if (ce) begin
      if (in_tlr) begin
        tdo_oe_q <= 1'b0;
      end else if (tck_fall) begin
        tdo_q <= so_mux;
        tdo_oe_q <= (st_q == S_SH_DR) | (st_q == S_SH_IR);
      end
    end
  end

  assign tdo = tdo_q;
  assign tdo_oe = tdo_oe_q;
endmodule

// *** verif/jir_tester.sv ***
`timescale 1ns/100ps
module jir_tester (
  input wire clk,
  input wire tdo,
  output logic tck,
  output logic tms,
  output logic tdi
);
  // tck rests low between frames; tdi rests at pad pull-up level
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // tdo read late in the high phase, well after the last fall settled
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    repeat (4) @(negedge clk);
    tck = 1'b1;
    repeat (4) @(negedge clk);
    o = tdo;
    tck = 1'b0;
  endtask
  task automatic tlr();
    logic o;
    repeat (5) step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
  endtask
  task automatic scan(input logic ir, input int n, input logic [296:0] din,
                      output logic [296:0] dout);
    logic o;
    dout = '0;
    step(1'b1, 1'b1, o);
    if (ir) step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
    step(1'b0, 1'b1, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
    tdi = 1'b1;
    repeat (8) @(negedge clk);
  endtask
endmodule

// *** verif/jir_top_monitor.sv ***
`timescale 1ns/100ps
`include "jir_regs.vh"
module jir_top_monitor #(
  parameter BSR_LEN = 297
) (
  input wire clk,
  input wire rst_n,
  input wire tck,
  input wire tdo,
  input wire bscan_ovr,
  input wire [BSR_LEN-1:0] bscan_en,
  input wire [`JIR_IR_W-1:0] cur_instr,
  input wire test_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire hz = cur_instr == `JIR_IR_HIGHZ;
  reset_idcode_a: assert property ($rose(rst_n) |-> cur_instr == `JIR_IR_IDCODE)
    else $error("instruction not idcode after reset");
  sticky_mode_a: assert property (test_mode |=> test_mode)
    else $error("test mode left without device reset");
  mode_source_a: assert property ($rose(test_mode) |-> cur_instr == `JIR_IR_EXTEST)
    else $error("test mode entered without extest");
  highz_float_a: assert property (hz [*6] |-> bscan_ovr && bscan_en == 0)
    else $error("pins not floated under highz");
  idle_pins_a: assert property ((!test_mode && !hz) [*6] |-> !bscan_ovr)
    else $error("pins taken outside test");
  ext_drive_a: assert property (test_mode [*6] |-> bscan_ovr)
    else $error("pins not driven from chain in test");
  no_drive_a: assert property (!test_mode [*6] |-> bscan_en == 0)
    else $error("pin driven without test mode");
  tdo_fall_a: assert property ($changed(tdo) |-> !tck)
    else $error("tdo moved while tck high");
  instr_fall_a: assert property ($changed(cur_instr) |-> !tck)
    else $error("instruction moved while tck high");
  cover property ($rose(test_mode));
  cover property (hz [*6]);
  cover property ($rose(bscan_ovr) && !test_mode);
endmodule
bind jir_top jir_top_monitor #(.BSR_LEN(BSR_LEN)) u_mon (
  .clk(clk), .rst_n(rst_n), .tck(tck), .tdo(tdo), .bscan_ovr(bscan_ovr),
  .bscan_en(bscan_en), .cur_instr(cur_instr), .test_mode(test_mode));

// *** verif/jir_top_tb.sv ***
`timescale 1ns/100ps
`include "jir_regs.vh"
module jir_top_tb;
  localparam int L = 297;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic trst_n = 1'b1;
  logic tck, tms, tdi, tdo, tdo_oe, ovr, mode;
  logic [L-1:0] pad = '0;
  logic [L-1:0] core = '1;
  logic [L-1:0] val, en, dout, exp;
  logic [4:0] instr;
  logic [4:0] bc [5] = '{5'h03, 5'h04, 5'h11, 5'h1e, 5'h1f};
  int bad_count = 0;
  int n_checks = 0;
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("mismatch at %0t: got %h want %h", $time, a, b); end end
  always #10 clk = ~clk;
  jir_tester u_tst (.clk(clk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi));
  // chain bit 2 acts as the enable of value bit 1
  jir_top #(.EN_MASK(297'h4)) i_dut (
    .clk(clk), .rst_n(rst_n), .ce(1'b1), .tck(tck), .tms(tms), .tdi(tdi),
    .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe), .pad_lvl(pad), .core_en(core),
    .bscan_ovr(ovr), .bscan_val(val), .bscan_en(en), .cur_instr(instr),
    .test_mode(mode));
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic ir(input logic [4:0] c);
    u_tst.scan(1'b1, 5, {292'h0, c}, dout);
    `CHK(dout[4:0], `JIR_IR_CAPTURE)
    `CHK(instr, c)
    `CHK(tdo_oe, 1'b0)
  endtask
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    `CHK(instr, `JIR_IR_IDCODE)
    u_tst.tlr();
    u_tst.scan(1'b0, 33, 297'h1, dout);
    `CHK(dout[32:0], {1'b1, 4'h1, 16'h1234, 11'h055, 1'b1})
    foreach (bc[k]) begin
      ir(bc[k]);
      u_tst.scan(1'b0, 2, 297'h1, dout);
      `CHK(dout[1:0], {1'b1, `JIR_BYP_CAPTURE})
      `CHK(ovr, bc[k] == `JIR_IR_HIGHZ)
    end
    u_tst.tlr();
    `CHK(instr, `JIR_IR_IDCODE)
    pad = {9{33'h1_2345_6789}};
    ir(`JIR_IR_SAMPLE);
    u_tst.scan(1'b0, L, ~pad, dout);
    exp = pad;
    exp[2] = core[2];
    `CHK(dout, exp)
    `CHK(val, ~pad)
    `CHK(mode, 1'b0)
    ir(`JIR_IR_EXTEST);
    `CHK(mode, 1'b1)
    `CHK(en[1], 1'b1)
    ir(`JIR_IR_HIGHZ);
    `CHK(en[1], 1'b0)
    `CHK(ovr, 1'b1)
    ir(`JIR_IR_EXTEST);
    `CHK(en[1], 1'b1)
    u_tst.scan(1'b0, L, pad, dout);
    exp[2] = 1'b1;
    `CHK(dout, exp)
    `CHK(val, pad)
    `CHK(en[1], 1'b0)
    ir(`JIR_IR_HIGHZ);
    trst_n = 1'b0;
    repeat (6) @(negedge clk);
    trst_n = 1'b1;
    repeat (6) @(negedge clk);
    `CHK(instr, `JIR_IR_IDCODE)
    `CHK(mode, 1'b1)
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    `CHK(mode, 1'b0)
    `CHK(ovr, 1'b0)
    summarize();
  end
  // whole run is under 200 us of scanning
  initial begin
    #1_000_000;
    bad_count++;
    summarize();
  end
endmodule
